/* shared/irq_comb_pkg.sv */
/*
  Constants, register map and request carrier of the event interrupt combiner.
  Assumes a single core clock and a plain one-cycle register port.
*/
package irq_comb_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_EVENTS = 128;
    localparam int NUM_WORDS  = 4;
    localparam int NUM_LINES  = 12;
    localparam int SEL_W      = 7;
    localparam int ADDR_W     = 12;
    localparam logic [3:0] FIRST_LINE = 4'h4;
    // ------------------------------------------------------------
    // fixed event numbers
    // ------------------------------------------------------------
    localparam int EV_DMA_GLOBAL = 34;
    localparam int EV_DMA_REG0   = 35;
    localparam int EV_DMA_REG1   = 36;
    localparam int EV_DROPPED    = 96;
    localparam int EV_IDMA_ERR   = 97;
    localparam int EV_EMU0       = 9;
    localparam int EV_EMU1       = 11;
    localparam int EV_EMU2       = 12;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] FLAG_BASE  = 12'h000;
    localparam logic [11:0] SET_BASE   = 12'h020;
    localparam logic [11:0] CLR_BASE   = 12'h040;
    localparam logic [11:0] MASK_BASE  = 12'h080;
    localparam logic [11:0] MFLAG_BASE = 12'h0A0;
    localparam logic [11:0] EXPM_BASE  = 12'h0C0;
    localparam logic [11:0] MEXP_BASE  = 12'h0E0;
    localparam logic [11:0] MUX_BASE   = 12'h100;
    localparam logic [11:0] XSTAT_BASE = 12'h180;
    localparam logic [1:0]  XSTAT_IDX  = 2'h0;
    localparam logic [1:0]  XCLR_IDX   = 2'h1;
    localparam logic [1:0]  DMASK_IDX  = 2'h2;
    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [127:0] MASK_RST  = {128{1'b1}};
    localparam logic [127:0] EXPM_RST  = {128{1'b1}};
    localparam logic [11:0]  DMASK_RST = 12'h000;
    localparam int STAT_LINE_LSB = 16;
    localparam int STAT_EVT_LSB  = 24;
    localparam int DMASK_LSB     = 4;
    // ------------------------------------------------------------
    // register request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
endpackage : irq_comb_pkg

/* src/event_interrupt_combiner.sv */
/*
  Event interrupt combiner: latches 128 system events, routes them onto
  12 prioritised cpu interrupt lines, makes the exception and emulation
  requests. Assumes event inputs are one-cycle pulses from logic on mclk.
*/
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module event_interrupt_combiner (
    // clock, reset, enable
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // register port
    input  wire irq_comb_pkg::reg_req_t bus_req,
    output logic [31:0]                rd_data,
    // system events
    input  wire logic [127:0]          periph_events,
    input  wire logic                  dma_channel_ctl_global_event,
    input  wire logic                  dma_channel_ctl_region0_event,
    input  wire logic                  dma_channel_ctl_region1_event,
    input  wire logic                  internal_dma_param_error_event,
    // cpu side
    output logic                       cpu_irq_valid,
    output logic [3:0]                 cpu_irq_num,
    input  wire logic                  cpu_irq_ack,
    output logic                       cpu_exception,
    output logic                       cpu_nmi,
    output logic [2:0]                 emu_irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [127:0] flag_reg;
    logic [127:0] mask_reg;
    logic [127:0] expm_reg;
    logic [127:0] ev_prev_reg;
    logic [6:0]   sel_reg [12];
    logic [11:0]  pend_reg;
    logic [11:0]  dmask_reg;
    logic         drop_evt_reg;
    logic         stat_valid_reg;
    logic [3:0]   stat_line_reg;
    logic [6:0]   stat_evt_reg;
    logic         valid_reg;
    logic [3:0]   num_reg;
    logic         exc_reg;
    logic [2:0]   emu_reg;
    logic [31:0]  rd_reg;
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic [7:0]  region = bus_req.addr[11:4];
    wire logic [1:0]  widx   = bus_req.addr[3:2];
    wire logic        wr_set = bus_req.wr && region == irq_comb_pkg::SET_BASE[11:4];
    wire logic        wr_clr = bus_req.wr && region == irq_comb_pkg::CLR_BASE[11:4];
    wire logic        wr_msk = bus_req.wr && region == irq_comb_pkg::MASK_BASE[11:4];
    wire logic        wr_exm = bus_req.wr && region == irq_comb_pkg::EXPM_BASE[11:4];
    wire logic        wr_mux = bus_req.wr && region == irq_comb_pkg::MUX_BASE[11:4];
    wire logic        in_xs  = region == irq_comb_pkg::XSTAT_BASE[11:4];
    wire logic        wr_xcl = bus_req.wr && in_xs && widx == irq_comb_pkg::XCLR_IDX;
    wire logic        wr_dmk = bus_req.wr && in_xs && widx == irq_comb_pkg::DMASK_IDX;
    // ------------------------------------------------------------
    // event vector
    // ------------------------------------------------------------
    logic [127:0] ev_now;
    logic [127:0] ev_edge;
    logic [127:0] mflag;
    logic [127:0] mexp;
    logic [127:0] set_sw;
    logic [127:0] clr_sw;
    logic [127:0] flag_next;
    logic [3:0]   comb_evt;
    assign ev_now = {periph_events[127:98],
                     internal_dma_param_error_event,
                     drop_evt_reg,
                     periph_events[95:37],
                     dma_channel_ctl_region1_event,
                     dma_channel_ctl_region0_event,
                     dma_channel_ctl_global_event,
                     periph_events[33:4],
                     comb_evt};
    assign ev_edge = ev_now & ~ev_prev_reg;
    assign mflag   = flag_reg & ~mask_reg;
    assign mexp    = flag_reg & ~expm_reg;
    assign flag_next = (flag_reg & ~clr_sw) | set_sw | ev_now;
    // ------------------------------------------------------------
    // per-word flag, mask and combined event logic
    // ------------------------------------------------------------
    genvar w;
    generate
        for (w = 0; w < irq_comb_pkg::NUM_WORDS; w++) begin : g_word
            wire logic hit = widx == 2'(w);
            assign set_sw[32*w +: 32] = (wr_set && hit) ? bus_req.wdata : 32'h0000_0000;
            assign clr_sw[32*w +: 32] = (wr_clr && hit) ? bus_req.wdata : 32'h0000_0000;
            assign comb_evt[w] = |mflag[32*w +: 32];
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    mask_reg[32*w +: 32] <= irq_comb_pkg::MASK_RST[32*w +: 32];
                    expm_reg[32*w +: 32] <= irq_comb_pkg::EXPM_RST[32*w +: 32];
                end else if (ce) begin
                    if (wr_msk && hit)
                        mask_reg[32*w +: 32] <= bus_req.wdata;
                    if (wr_exm && hit)
                        expm_reg[32*w +: 32] <= bus_req.wdata;
                end
            end
        end
    endgenerate
    // ------------------------------------------------------------
    // cpu lines
    // ------------------------------------------------------------
    logic [11:0] hit_line;
    logic [11:0] ack_clr;
    logic [11:0] drop;
    logic [11:0] pend_next;
    genvar i;
    generate
        for (i = 0; i < irq_comb_pkg::NUM_LINES; i++) begin : g_line
            wire logic [3:0] line_no = irq_comb_pkg::FIRST_LINE + 4'(i);
            wire logic mux_hit = wr_mux && widx == 2'(i / 4 + 1);
            assign hit_line[i] = ev_edge[sel_reg[i]];
            assign ack_clr[i]  = cpu_irq_ack && num_reg == line_no;
            assign drop[i] = hit_line[i] & pend_reg[i] & ~ack_clr[i]
                             & ~dmask_reg[i];
            always_ff @(posedge mclk) begin
                if (!rst_n)
                    sel_reg[i] <= 7'(line_no);
                else if (ce && mux_hit)
                    sel_reg[i] <= bus_req.wdata[8*(i%4) +: 7];
            end
        end
    endgenerate
    assign pend_next = (pend_reg & ~ack_clr) | hit_line;
    function automatic logic [3:0] lowest(input logic [11:0] p);
        logic [3:0] idx;
        idx = 4'h0;
        for (int k = 11; k >= 0; k--) begin
            if (p[k])
                idx = 4'(k);
        end
        return idx;
    endfunction : lowest
    wire logic       drop_any = |drop;
    wire logic [3:0] drop_idx = lowest(drop);
    wire logic       xclr     = wr_xcl && bus_req.wdata[0];
    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire logic [6:0]  boff = {widx, 5'h00};
    wire logic [31:0] xstat_word = {1'b0, stat_evt_reg, 4'h0, stat_line_reg,
                                    15'h0000, stat_valid_reg};
    wire logic [31:0] mux_word = {1'b0, sel_reg[4*widx - 4 + 3],
                                  1'b0, sel_reg[4*widx - 4 + 2],
                                  1'b0, sel_reg[4*widx - 4 + 1],
                                  1'b0, sel_reg[4*widx - 4]};
    wire logic [31:0] rd_word =
        region == irq_comb_pkg::FLAG_BASE[11:4]  ? flag_reg[boff +: 32] :
        region == irq_comb_pkg::MASK_BASE[11:4]  ? mask_reg[boff +: 32] :
        region == irq_comb_pkg::MFLAG_BASE[11:4] ? mflag[boff +: 32] :
        region == irq_comb_pkg::EXPM_BASE[11:4]  ? expm_reg[boff +: 32] :
        region == irq_comb_pkg::MEXP_BASE[11:4]  ? mexp[boff +: 32] :
        (region == irq_comb_pkg::MUX_BASE[11:4] && widx != 2'h0) ? mux_word :
        (in_xs && widx == irq_comb_pkg::XSTAT_IDX) ? xstat_word :
        (in_xs && widx == irq_comb_pkg::DMASK_IDX) ?
            {16'h0000, dmask_reg, 4'h0} : 32'h0000_0000;
    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_reg    <= '0;
            ev_prev_reg <= '0;
            pend_reg    <= 12'h000;
            valid_reg   <= 1'b0;
            num_reg     <= irq_comb_pkg::FIRST_LINE;
            rd_reg      <= 32'h0000_0000;
        end else if (ce) begin
            flag_reg    <= flag_next;
            ev_prev_reg <= ev_now;
            pend_reg    <= pend_next;
            valid_reg   <= |pend_next;
            num_reg     <= irq_comb_pkg::FIRST_LINE + lowest(pend_next);
            rd_reg      <= bus_req.rd ? rd_word : 32'h0000_0000;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dmask_reg    <= irq_comb_pkg::DMASK_RST;
            drop_evt_reg <= 1'b0;
            exc_reg      <= 1'b0;
            emu_reg      <= 3'h0;
        end else if (ce) begin
            if (wr_dmk)
                dmask_reg <= bus_req.wdata[irq_comb_pkg::DMASK_LSB +: 12];
            drop_evt_reg <= drop_any;
            exc_reg      <= |mexp;
            emu_reg      <= {ev_now[irq_comb_pkg::EV_EMU2], ev_now[irq_comb_pkg::EV_EMU1],
                             ev_now[irq_comb_pkg::EV_EMU0]};
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stat_valid_reg <= 1'b0;
            stat_line_reg  <= 4'h0;
            stat_evt_reg   <= 7'h00;
        end else if (ce) begin
            if (drop_any && !stat_valid_reg) begin
                stat_valid_reg <= 1'b1;
                stat_line_reg  <= irq_comb_pkg::FIRST_LINE + drop_idx;
                stat_evt_reg   <= sel_reg[drop_idx];
            end else if (xclr && !drop_any) begin
                stat_valid_reg <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data       = rd_reg;
    assign cpu_irq_valid = valid_reg;
    assign cpu_irq_num   = num_reg;
    assign cpu_exception = exc_reg;
    assign cpu_nmi       = 1'b0;
    assign emu_irq       = emu_reg;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    nmi_tied_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cpu_nmi == 1'b0) else $error("nmi driven");
    valid_pend_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cpu_irq_valid == (pend_reg != 12'h000)) else $error("valid mismatch");
    route_line_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && ev_edge[sel_reg[3]] |=> pend_reg[3] && cpu_irq_valid)
        else $error("routed event lost");
    prio_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pend_reg[0] |-> cpu_irq_num == 4'h4) else $error("priority wrong");
    drop_event_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && drop_any ##1 ce |=> flag_reg[96]) else $error("drop event missing");
    drop_stat_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && drop_any |=> stat_valid_reg) else $error("drop status missing");
    idma_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && internal_dma_param_error_event |=> flag_reg[97])
        else $error("event 97 missing");
    dma_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && dma_channel_ctl_region1_event |=> flag_reg[36] && ev_prev_reg[36])
        else $error("event 36 missing");
    mux_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && wr_mux && widx == 2'h1 |=> sel_reg[0] == $past(bus_req.wdata[6:0]))
        else $error("routing write lost");
    comb_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && mflag[40] |=> flag_reg[1]) else $error("combined event lost");
    exc_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && mexp != '0 |=> cpu_exception) else $error("exception missing");
    lost_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        dmask_reg == 12'hFFF |-> !drop_any) else $error("masked line dropped");
    emu_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && periph_events[9] |=> emu_irq[0]) else $error("emulation request lost");
    emu_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && periph_events[12] |=> emu_irq[2])
        else $error("third emulation request lost");
    ack_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && cpu_irq_ack && cpu_irq_num == irq_comb_pkg::FIRST_LINE && !hit_line[0]
        |=> !pend_reg[0]) else $error("ack did not clear line");
    prio_next_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pend_reg[1:0] == 2'h2 |-> cpu_irq_num == 4'h5)
        else $error("second line priority wrong");
    idle_num_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pend_reg == 12'h000 |-> cpu_irq_num == irq_comb_pkg::FIRST_LINE)
        else $error("idle line number wrong");
    exc_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && mexp == '0 |=> !cpu_exception)
        else $error("exception stuck");
    stat_line_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && drop_any && !stat_valid_reg |=> stat_line_reg == irq_comb_pkg::FIRST_LINE
        + $past(drop_idx)) else $error("drop line wrong");
    dma_glob_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && dma_channel_ctl_global_event |=> flag_reg[34] && ev_prev_reg[34])
        else $error("event 34 missing");
    flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && wr_clr && widx == 2'h3 && bus_req.wdata[0] && !drop_evt_reg
        |=> !flag_reg[96]) else $error("flag clear lost");
    freeze_state_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !ce |=> $stable(pend_reg) && $stable(flag_reg))
        else $error("state moved while frozen");
    drop_c: cover property (@(posedge mclk) disable iff (!rst_n) drop_any);
    exc_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(cpu_exception));
    two_pend_c: cover property (@(posedge mclk) disable iff (!rst_n)
        pend_reg[0] && pend_reg[2]);
    drop_masked_c: cover property (@(posedge mclk) disable iff (!rst_n)
        hit_line[3] && pend_reg[3] && dmask_reg[3]);
    ack_c: cover property (@(posedge mclk) disable iff (!rst_n)
        cpu_irq_valid && cpu_irq_ack);
endmodule : event_interrupt_combiner
`default_nettype wire

/* tb/cpu_core_model.sv */
/*
  Behavioural model of the processor core that takes prioritised interrupts.
  Assumes the combiner shows a level request and takes a one-cycle ack on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // interrupt request from the combiner
    input  wire logic       cpu_irq_valid,
    input  wire logic [3:0] cpu_irq_num,
    output logic            cpu_irq_ack,
    // test control and record of served lines
    input  wire logic       stall,
    output logic [7:0]      served_log
);
    // ----------------------------------------------------------------
    // service: one ack per request, none while stalled
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cpu_irq_ack <= 1'b0;
            served_log  <= 8'h00;
        end else if (cpu_irq_ack) begin
            cpu_irq_ack <= 1'b0;
        end else if (cpu_irq_valid && !stall) begin
            cpu_irq_ack <= 1'b1;
            served_log  <= {served_log[3:0], cpu_irq_num};
        end
    end
endmodule : cpu_core_model
`default_nettype wire

/* tb/event_interrupt_combiner_tb.sv */
/*
  Self-checking bench of the event interrupt combiner with a core model.
  Assumes the combiner package is compiled first; ce is held high except in the freeze test.
*/
`timescale 1ns/100ps
`default_nettype none
module event_interrupt_combiner_tb;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic                   mclk          = 1'b0;
    logic                   rst_n         = 1'b0;
    logic                   ce            = 1'b1;
    irq_comb_pkg::reg_req_t bus_req       = '0;
    logic [127:0]           periph_events = '0;
    logic [3:0]             dev_ev        = 4'h0;
    logic                   stall         = 1'b0;
    logic [31:0]            rd_data;
    logic                   cpu_irq_valid;
    logic [3:0]             cpu_irq_num;
    logic                   cpu_irq_ack;
    logic                   cpu_exception;
    logic                   cpu_nmi;
    logic [2:0]             emu_irq;
    logic [7:0]             served_log;
    logic [31:0]            d;
    int                     n_mismatch    = 0;
    int                     total_checks  = 0;

    always #25 mclk = ~mclk;

    event_interrupt_combiner u_event_interrupt_combiner (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
        .periph_events(periph_events), .dma_channel_ctl_global_event(dev_ev[1]),
        .dma_channel_ctl_region0_event(dev_ev[0]), .dma_channel_ctl_region1_event(dev_ev[2]),
        .internal_dma_param_error_event(dev_ev[3]), .cpu_irq_valid(cpu_irq_valid),
        .cpu_irq_num(cpu_irq_num), .cpu_irq_ack(cpu_irq_ack),
        .cpu_exception(cpu_exception), .cpu_nmi(cpu_nmi), .emu_irq(emu_irq));

    cpu_core_model u_cpu_core_model (
        .mclk(mclk), .rst_n(rst_n), .cpu_irq_valid(cpu_irq_valid),
        .cpu_irq_num(cpu_irq_num), .cpu_irq_ack(cpu_irq_ack), .stall(stall),
        .served_log(served_log));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic reg_write(input logic [11:0] a, input logic [31:0] v);
        @(posedge mclk);
        bus_req.wr    <= 1'b1;
        bus_req.addr  <= a;
        bus_req.wdata <= v;
        @(posedge mclk);
        bus_req.wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [11:0] a, output logic [31:0] v);
        @(posedge mclk);
        bus_req.rd   <= 1'b1;
        bus_req.addr <= a;
        @(posedge mclk);
        bus_req.rd   <= 1'b0;
        #1 v = rd_data;
    endtask : reg_read

    task automatic pulse(input logic [127:0] pe, input logic [3:0] de);
        @(posedge mclk);
        periph_events <= pe;
        dev_ev        <= de;
        @(posedge mclk);
        periph_events <= '0;
        dev_ev        <= 4'h0;
    endtask : pulse

    task automatic wait_level(input logic want);
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            #1;
            if (cpu_irq_valid === want) return;
        end
        n_mismatch++;
        $display("ERROR at %0t: wait ran out, got %h expected %h", $time, cpu_irq_valid, want);
        report_and_stop;
    endtask : wait_level

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset;
        logic [11:0] a [5] = '{12'h080, 12'h0C0, 12'h188, 12'h1F0, 12'h104};
        logic [31:0] e [5] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h07060504};
        check_val({31'h0, cpu_nmi}, 32'h0);
        check_val({28'h0, cpu_irq_num}, 32'h4);
        check_val({27'h0, cpu_irq_valid, cpu_exception, emu_irq}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            reg_read(a[i], d);
            check_val(d, e[i]);
        end
        @(posedge mclk);
        #1 check_val(rd_data, 32'h0);
        $display("test reset done");
    endtask : test_reset

    task automatic test_route;
        reg_write(12'h104, 32'h28242322);
        reg_read(12'h104, d);
        check_val(d, 32'h28242322);
        stall = 1'b1;
        pulse('0, 4'h1);
        wait_level(1'b1);
        check_val({28'h0, cpu_irq_num}, 32'h5);
        stall = 1'b0;
        wait_level(1'b0);
        check_val({28'h0, served_log[3:0]}, 32'h5);
        $display("test route done");
    endtask : test_route

    task automatic test_priority;
        stall = 1'b1;
        pulse('0, 4'h6);
        wait_level(1'b1);
        repeat (2) @(posedge mclk);
        #1 check_val({28'h0, cpu_irq_num}, 32'h4);
        stall = 1'b0;
        wait_level(1'b0);
        repeat (4) @(posedge mclk);
        check_val({24'h0, served_log}, 32'h46);
        $display("test priority done");
    endtask : test_priority

    task automatic test_masks;
        reg_write(12'h084, 32'h0);
        reg_read(12'h0A4, d);
        check_val(d, 32'h1C);
        reg_write(12'h0CC, 32'hFFFFFFFD);
        pulse('0, 4'h8);
        repeat (3) @(posedge mclk);
        #1 check_val({31'h0, cpu_exception}, 32'h1);
        reg_read(12'h0EC, d);
        check_val(d, 32'h2);
        reg_write(12'h04C, 32'h2);
        repeat (3) @(posedge mclk);
        #1 check_val({31'h0, cpu_exception}, 32'h0);
        $display("test masks done");
    endtask : test_masks

    task automatic test_drop;
        stall = 1'b1;
        pulse(128'h1 << 40, 4'h0);
        wait_level(1'b1);
        reg_write(12'h044, 32'h100);
        pulse(128'h1 << 40, 4'h0);
        repeat (4) @(posedge mclk);
        reg_read(12'h00C, d);
        check_val(d, 32'h1);
        reg_read(12'h180, d);
        check_val(d, 32'h28070001);
        reg_write(12'h184, 32'h1);
        reg_write(12'h04C, 32'h1);
        reg_write(12'h188, 32'h80);
        reg_write(12'h044, 32'h100);
        pulse(128'h1 << 40, 4'h0);
        repeat (4) @(posedge mclk);
        reg_read(12'h00C, d);
        check_val(d, 32'h0);
        stall = 1'b0;
        wait_level(1'b0);
        $display("test drop done");
    endtask : test_drop

    task automatic test_emu;
        int ev [3] = '{9, 11, 12};
        for (int k = 0; k < 3; k++) begin
            pulse(128'h1 << ev[k], 4'h0);
            #1 check_val({29'h0, emu_irq}, 32'h1 << k);
            wait_level(1'b0);
        end
        $display("test emu done");
    endtask : test_emu

    task automatic test_freeze;
        @(posedge mclk);
        ce <= 1'b0;
        pulse(128'h1 << 9, 4'h0);
        repeat (2) @(posedge mclk);
        #1 check_val({28'h0, cpu_irq_valid, emu_irq}, 32'h0);
        @(posedge mclk);
        ce <= 1'b1;
        $display("test freeze done");
    endtask : test_freeze

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        test_reset;
        test_route;
        test_priority;
        test_masks;
        test_drop;
        test_emu;
        test_freeze;
        report_and_stop;
    end
endmodule : event_interrupt_combiner_tb
`default_nettype wire
